//--- core/sbwk_pkg.sv
// package: register map, field positions and carrier types for the standby wake enables
package sbwk_pkg;

	// register byte offset on the bus
	localparam logic [3:0] ENABLES_OFFSET = 4'h0;
	// status register: registered wake request and live standby state
	localparam logic [3:0] STATUS_OFFSET = 4'h4;

	// field positions
	localparam int EXT_PIN_LSB = 0;
	localparam int EXT_PIN_WIDTH = 8;
	localparam int WDT_BIT = 16;
	localparam int KEY_BIT = 17;
	localparam int VD1_BIT = 18;
	localparam int VD2_BIT = 19;
	localparam int RSV_LSB = 20;
	localparam int CMP_BIT = 23;

	// writable bits; everything else reads zero
	localparam logic [31:0] WRITABLE_MASK = 32'h008f_00ff;
	localparam logic [31:0] ENABLES_RESET = 32'h0000_0000;

	// interrupt sources that may end standby
	typedef struct packed {
		logic cmp;
		logic vd2;
		logic vd1;
		logic key;
		logic wdt;
		logic [7:0] ext_pin;
	} sbwk_src_t;

	// wishbone request bundle
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} sbwk_wb_req_t;

endpackage

//--- core/sbwk_wake_enable.sv
// standby wake source enable register with wishbone slave and wake request gating
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps

module sbwk_wake_enable
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire sbwk_pkg::sbwk_wb_req_t wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire sbwk_pkg::sbwk_src_t irq_src_i,
	input wire logic standby_i,
	output logic wake_o,
	output sbwk_pkg::sbwk_src_t wake_src_o
);

	// stored enables
	logic [31:0] enables_reg;
	logic [31:0] enables_next;

	// read data, held until the next read
	logic [31:0] rdat_reg;
	logic [31:0] rdat_next;

	// one-cycle bus answers
	logic ack_reg;
	logic ack_next;
	logic err_reg;
	logic err_next;

	// gated sources and the wake request
	sbwk_pkg::sbwk_src_t gated_reg;
	sbwk_pkg::sbwk_src_t gated_next;
	logic wake_reg;
	logic wake_next;

	// bus decode
	logic req;
	logic hit_en;
	logic hit_st;
	logic wr_en;
	logic rd_any;
	logic [31:0] bytemask;
	logic [31:0] status_word;

	// named views of the stored enable fields
	logic [7:0] ext_pin_wake_enables;
	logic ind_watchdog_wake_enable;
	logic key_input_wake_enable;
	logic volt_detect_one_wake_enable;
	logic volt_detect_two_wake_enable;
	logic low_power_comparator_wake_enable;

	// new access only while no answer is out, so a held request is taken once
	assign req = wb_req_i.cyc & wb_req_i.stb & ~ack_reg & ~err_reg;
	assign hit_en = wb_req_i.adr == sbwk_pkg::ENABLES_OFFSET;
	assign hit_st = wb_req_i.adr == sbwk_pkg::STATUS_OFFSET;
	assign wr_en = req & wb_req_i.we & hit_en; // status writes are acked, ignored
	assign rd_any = req & ~wb_req_i.we & (hit_en | hit_st);

	// byte lanes choose which bytes a write touches
	assign bytemask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}}, {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

	// status word: registered wake above live standby level
	assign status_word = {30'h0000_0000, wake_reg, standby_i};

	// answer pulse: ack for a mapped address, err otherwise
	always_comb
	begin
		ack_next = 1'b0;
		err_next = 1'b0;
		if (req)
		begin
			if (hit_en || hit_st)
			begin
				ack_next = 1'b1;
			end
			else
			begin
				err_next = 1'b1; // unmapped, no effect
			end
		end
	end

	// answer registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
		end
		else
		begin
			ack_reg <= ack_next;
			err_reg <= err_next;
		end
	end

	// byte-lane merge; reserved and unused bits never store
	always_comb
	begin
		enables_next = enables_reg;
		if (wr_en)
		begin
			enables_next = ((enables_reg & ~bytemask) | (wb_req_i.dat & bytemask))
				& sbwk_pkg::WRITABLE_MASK;
		end
	end

	// enable register; all sources blocked after reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			enables_reg <= sbwk_pkg::ENABLES_RESET;
		end
		else
		begin
			enables_reg <= enables_next;
		end
	end

	// read data taken with the access, reserved bits forced low
	always_comb
	begin
		rdat_next = rdat_reg;
		if (rd_any)
		begin
			if (hit_en)
			begin
				rdat_next = enables_reg & sbwk_pkg::WRITABLE_MASK;
			end
			else
			begin
				rdat_next = status_word;
			end
		end
	end

	// read data register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rdat_reg <= 32'h0000_0000;
		end
		else
		begin
			rdat_reg <= rdat_next;
		end
	end

	// bus outputs
	assign wb_dat_o = rdat_reg;
	assign wb_ack_o = ack_reg;
	assign wb_err_o = err_reg;

	// field views of the enable register
	assign ext_pin_wake_enables = enables_reg[sbwk_pkg::EXT_PIN_LSB +: sbwk_pkg::EXT_PIN_WIDTH];
	assign ind_watchdog_wake_enable = enables_reg[sbwk_pkg::WDT_BIT];
	assign key_input_wake_enable = enables_reg[sbwk_pkg::KEY_BIT];
	assign volt_detect_one_wake_enable = enables_reg[sbwk_pkg::VD1_BIT];
	assign volt_detect_two_wake_enable = enables_reg[sbwk_pkg::VD2_BIT];
	assign low_power_comparator_wake_enable = enables_reg[sbwk_pkg::CMP_BIT];

	// gate each source by its enable, not by standby
	always_comb
	begin
		gated_next.ext_pin = irq_src_i.ext_pin & ext_pin_wake_enables;
		gated_next.wdt = irq_src_i.wdt & ind_watchdog_wake_enable;
		gated_next.key = irq_src_i.key & key_input_wake_enable;
		gated_next.vd1 = irq_src_i.vd1 & volt_detect_one_wake_enable;
		gated_next.vd2 = irq_src_i.vd2 & volt_detect_two_wake_enable;
		gated_next.cmp = irq_src_i.cmp & low_power_comparator_wake_enable;
	end

	// gated source register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			gated_reg <= '0;
		end
		else
		begin
			gated_reg <= gated_next;
		end
	end

	// wake request only while the device sits in standby
	always_comb
	begin
		wake_next = standby_i & (|gated_next);
	end

	// wake register, same cycle as the gated sources
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wake_reg <= 1'b0;
		end
		else
		begin
			wake_reg <= wake_next;
		end
	end

	// wake outputs
	assign wake_o = wake_reg;
	assign wake_src_o = gated_reg;

endmodule

//--- sim/sbwk_sva.sv
// wake enable checker
`timescale 1ns/1ps
module sbwk_sva
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire sbwk_pkg::sbwk_src_t irq_src_i,
	input wire logic standby_i,
	input wire logic wake_o,
	input wire sbwk_pkg::sbwk_src_t wake_src_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_v1; wake_src_o[10]|->$past(irq_src_i[10]); endproperty
	a_v1: assert property(p_v1) else $error("v1");
	property p_v2; wake_src_o[11]|->$past(irq_src_i[11]); endproperty
	a_v2: assert property(p_v2) else $error("v2");
	property p_cp; wake_src_o[12]|->$past(irq_src_i[12]); endproperty
	a_cp: assert property(p_cp) else $error("cp");
	property p_rs; wb_ack_o|->wb_dat_o[22:20]==3'h0; endproperty
	a_rs: assert property(p_rs) else $error("rs");
	property p_pn; (wake_src_o[9:0]&~$past(irq_src_i[9:0]))==10'h0; endproperty
	a_pn: assert property(p_pn) else $error("pn");
	property p_wk; wake_o==($past(standby_i)&&(|wake_src_o)); endproperty
	a_wk: assert property(p_wk) else $error("wk");
	property p_ak; wb_ack_o|=>!wb_ack_o; endproperty
	a_ak: assert property(p_ak) else $error("ak");
	c_a: cover property(wb_ack_o);
	c_b: cover property(wake_src_o[10]);
	c_c: cover property(wake_src_o[12]);
	c_d: cover property(wake_o);
endmodule
bind sbwk_wake_enable sbwk_sva i_sbwk_sva(.clk_i(clk_i),.rst_i(rst_i),.wb_dat_o(wb_dat_o),.wb_ack_o(wb_ack_o),
	.irq_src_i(irq_src_i),.standby_i(standby_i),.wake_o(wake_o),.wake_src_o(wake_src_o));

//--- sim/tb_sbwk_wake_enable.sv
// wake enable bench
`timescale 1ns/1ps
`define CK(a,b) begin n_tests++;if((a)!==(b))begin num_errors++;$display("[FAIL] %0t %h %h",$time,a,b);end end
module tb_sbwk_wake_enable;
	logic clk_i=0,rst_i=1,standby_i=1,wake_o,wb_ack_o,wb_err_o;
	logic [31:0] wb_dat_o;
	sbwk_pkg::sbwk_wb_req_t wb_req_i='0;
	sbwk_pkg::sbwk_src_t irq_src_i='0,wake_src_o;
	int num_errors=0,n_tests=0,n=0;
	sbwk_wake_enable i_sbwk_wake_enable(.clk_i(clk_i),.rst_i(rst_i),.wb_req_i(wb_req_i),.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),.wb_err_o(wb_err_o),.irq_src_i(irq_src_i),.standby_i(standby_i),.wake_o(wake_o),
		.wake_src_o(wake_src_o));
	always #12.5 clk_i=~clk_i;
	// hang guard
	always @(posedge clk_i) if(++n>500) wrap_up(1);
	task wrap_up(input int t);
		num_errors+=t;
		$display("%0d %0d",num_errors,n_tests);
		if(num_errors==0&&n_tests>0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one classic bus cycle
	task wb(input logic w,input logic [3:0] a,input logic [3:0] s,input logic [31:0] d);
		@(posedge clk_i) wb_req_i<={2'b11,w,a,s,d};
		do @(posedge clk_i); while(!wb_ack_o&&!wb_err_o);
		wb_req_i<='0;
	endtask
	// reset value, masking, byte lanes, status write ignored, unmapped error
	task t_reg;
		wb(1'b0,4'h0,4'hf,32'h0);
		`CK(wb_dat_o,32'h0)
		wb(1'b1,4'h0,4'hf,32'hff8f_ffff);
		wb(1'b0,4'h0,4'hf,32'h0);
		`CK(wb_dat_o,32'h008f_00ff)
		wb(1'b1,4'h0,4'h4,32'h0);
		wb(1'b0,4'h0,4'hf,32'h0);
		`CK(wb_dat_o,32'h0000_00ff)
		wb(1'b1,4'h4,4'hf,32'h008f_00ff);
		wb(1'b0,4'h0,4'hf,32'h0);
		`CK(wb_dat_o,32'h0000_00ff)
		wb(1'b0,4'h8,4'hf,32'h0);
		`CK(wb_err_o,1'b1)
	endtask
	// outside standby: gated source shows, no wake; status tracks both
	task t_idle;
		wb(1'b1,4'h0,4'hf,32'h0004_0000);
		standby_i<=1'b0;
		irq_src_i<=13'h0400;
		repeat(2) @(posedge clk_i);
		`CK({wake_o,wake_src_o},{1'b0,13'h0400})
		wb(1'b0,4'h4,4'hf,32'h0);
		`CK(wb_dat_o,32'h0000_0000)
		standby_i<=1'b1;
		repeat(2) @(posedge clk_i);
		`CK({wake_o,wake_src_o},{1'b1,13'h0400})
		wb(1'b0,4'h4,4'hf,32'h0);
		`CK(wb_dat_o,32'h0000_0003)
	endtask
	// reset in mid-run clears enables and wake outputs
	task t_rst;
		irq_src_i<='1;
		rst_i<=1'b1;
		repeat(2) @(posedge clk_i);
		`CK({wake_o,wake_src_o},14'h0)
		rst_i<=1'b0;
		repeat(2) @(posedge clk_i);
		`CK({wake_o,wake_src_o},14'h0)
		irq_src_i<='0;
		wb(1'b0,4'h0,4'hf,32'h0);
		`CK(wb_dat_o,32'h0)
	endtask
	task t_gate;
		for(int i=0;i<13;i++)
		begin
			wb(1'b1,4'h0,4'hf,32'h1<<(i<8?i:i<12?i+8:23));
			irq_src_i<='1;
			repeat(2) @(posedge clk_i);
			`CK({wake_o,wake_src_o},{1'b1,13'h1<<i})
			irq_src_i<='0;
		end
	endtask
	initial
	begin
		repeat(5) @(posedge clk_i);
		rst_i<=1'b0;
		t_reg;
		t_gate;
		t_idle;
		t_rst;
		wrap_up(0);
	end
endmodule
